// file: hw/bus_cycle_unit.sv
// Purpose: Bus interface of an 8-bit-bus processor, driven by software requests.
// Assumes: AHB-Lite single word transfers; ready pin is asynchronous.
// Notes:   Word requests become two byte cycles, low byte first.
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

module bus_cycle_unit
   import bus_cycle_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hsel_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        mode_strap_in,
   input  wire logic        ready_in,
   input  wire logic [7:0]  low_addr_data_lines_in,
   output logic      [7:0]  low_addr_data_lines_out,
   output logic             low_addr_data_lines_oe_out,
   output logic      [7:0]  middle_address_lines_out,
   output logic      [3:0]  upper_addr_status_lines_out,
   output logic             addr_latch_out,
   output logic             cycle_status_bit0_out,
   output logic             cycle_status_bit1_out,
   output logic             cycle_status_bit2_out,
   output logic             data_enable_n_out,
   output logic             transmit_receive_dir_out,
   output logic             lock_n_out,
   output logic      [1:0]  queue_status_out,
   output logic             min_mode_out,
   output logic             busy_out
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_T1   = 6'h02,
      ST_T2   = 6'h04,
      ST_T3   = 6'h08,
      ST_TW   = 6'h10,
      ST_T4   = 6'h20
   } bstate_type;

   bstate_type  state_reg, state_next;
   logic [15:0] cs_reg, ss_reg, ds_reg, es_reg, ip_reg;
   logic [31:0] req_reg, wdata_reg, rdata_reg;
   logic        ie_reg;
   logic [3:0]  idle_cfg_reg, idle_cnt_reg;
   logic        pend_reg, boot_reg;
   logic [1:0]  byte_idx_reg, byte_last_reg;
   logic [15:0] off_reg;
   logic        mode_meta_reg, mode_sync_reg, rdy_meta_reg, rdy_sync_reg;
   logic        ph_valid_reg, ph_write_reg;
   logic [7:0]  ph_addr_reg;
   logic [2:0]  kind;
   logic [1:0]  seg_sel;
   logic [15:0] seg_base;
   logic [19:0] phys;
   logic        is_io, is_wr;
   logic [2:0]  cyc_code;
   cycle_req_type cur;
   pins_type    pins_next;
   logic        wr_en, req_wr;

   // Two-flop synchronisers for the strap and the ready pin.
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         mode_meta_reg <= 1'b0;
         mode_sync_reg <= 1'b0;
         rdy_meta_reg  <= 1'b0;
         rdy_sync_reg  <= 1'b0;
      end
      else
      begin
         mode_meta_reg <= mode_strap_in;
         mode_sync_reg <= mode_meta_reg;
         rdy_meta_reg  <= ready_in;
         rdy_sync_reg  <= rdy_meta_reg;
      end
   end

   // AHB-Lite address phase capture; every access is zero wait state.
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg  <= 8'h00;
      end
      else if (hready_in)
      begin
         ph_valid_reg <= hsel_in && htrans_in[1];
         ph_write_reg <= hwrite_in;
         ph_addr_reg  <= haddr_in[7:0];
      end
   end

   assign wr_en  = ph_valid_reg && ph_write_reg;
   // A request is refused while a previous one is still running.
   assign req_wr = wr_en && ph_addr_reg == REQ_OFS && !pend_reg;

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cs_reg       <= RESET_CS;
         ss_reg       <= RESET_SEG;
         ds_reg       <= RESET_SEG;
         es_reg       <= RESET_SEG;
         ie_reg       <= 1'b0;
         idle_cfg_reg <= IDLE_RESET;
         req_reg      <= 32'h0000_0000;
         wdata_reg    <= 32'h0000_0000;
      end
      else
      begin
         if (wr_en && ph_addr_reg == CTRL_OFS)
         begin
            ie_reg       <= hwdata_in[CTRL_IE_BIT];
            idle_cfg_reg <= hwdata_in[CTRL_IDLE_LSB +: CTRL_IDLE_W];
         end
         else if (wr_en && ph_addr_reg == SEG_SS_OFS)
            ss_reg <= hwdata_in[15:0];
         else if (wr_en && ph_addr_reg == SEG_DS_OFS)
            ds_reg <= hwdata_in[15:0];
         else if (wr_en && ph_addr_reg == SEG_ES_OFS)
            es_reg <= hwdata_in[15:0];
         else if (wr_en && ph_addr_reg == WDATA_OFS)
            wdata_reg <= hwdata_in;
         else if (req_wr)
            req_reg <= hwdata_in;
         // Vector completion loads the code base from the second word.
         if (state_reg == ST_T4 && rdy_sync_reg && req_reg[18:16] == KIND_VECTOR
             && byte_idx_reg == byte_last_reg)
            cs_reg <= {low_addr_data_lines_in, rdata_reg[23:16]};
         else if (wr_en && ph_addr_reg == SEG_CS_OFS)
            cs_reg <= hwdata_in[15:0];
      end
   end

   assign kind = req_reg[REQ_KIND_LSB +: 3];

   seg_select u_seg
   (
      .kind_in    (kind),
      .bp_rel_in  (req_reg[23]),
      .ovr_in     (req_reg[REQ_OVR_BIT]),
      .ovr_seg_in (req_reg[REQ_SEG_LSB +: 2]),
      .seg_out    (seg_sel)
   );

   always_comb
   begin
      if (kind == KIND_VECTOR)
         seg_base = VECTOR_BASE[19:4];
      else if (seg_sel == SEG_CODE)
         seg_base = cs_reg;
      else if (seg_sel == SEG_STACK)
         seg_base = ss_reg;
      else if (seg_sel == SEG_DATA)
         seg_base = ds_reg;
      else
         seg_base = es_reg;
   end

   assign is_io = kind == KIND_IORD || kind == KIND_IOWR;
   assign is_wr = kind == KIND_MEMWR || kind == KIND_IOWR;

   phys_addr_gen u_addr
   (
      .seg_base_in  (seg_base),
      .offset_in    (off_reg),
      .is_io_in     (is_io),
      .direct_io_in (req_reg[REQ_DIR_BIT]),
      .phys_out     (phys)
   );

   always_comb
   begin
      // Cycle-type encodings.
      case (kind)
         KIND_FETCH:  cyc_code = CYC_FETCH;
         KIND_IORD:   cyc_code = CYC_IORD;
         KIND_IOWR:   cyc_code = CYC_IOWR;
         KIND_MEMWR:  cyc_code = CYC_MEMWR;
         default:     cyc_code = CYC_MEMRD;
      endcase
      if (boot_reg)
         cyc_code = CYC_FETCH;
   end

   assign cur = '{addr: phys, cyc: cyc_code, seg: is_io ? SEG_CODE : seg_sel,
                  is_io: is_io, is_write: is_wr && !boot_reg};

   // Bus state sequence: T1, T2, T3, waits, T4, then optional idles.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (pend_reg && idle_cnt_reg == 4'h0) state_next = ST_T1;
         ST_T1:   state_next = ST_T2;
         ST_T2:   state_next = ST_T3;
         ST_T3:   state_next = rdy_sync_reg ? ST_T4 : ST_TW;
         ST_TW:   state_next = rdy_sync_reg ? ST_T4 : ST_TW;
         ST_T4:   state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Request bookkeeping: byte counts, offset stepping and read capture.
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pend_reg      <= 1'b1;
         boot_reg      <= 1'b1;
         off_reg       <= RESET_IP;
         ip_reg        <= RESET_IP;
         byte_idx_reg  <= 2'h0;
         byte_last_reg <= 2'h0;
         idle_cnt_reg  <= IDLE_RESET;
         rdata_reg     <= 32'h0000_0000;
      end
      else
      begin
         if (req_wr)
         begin
            pend_reg     <= 1'b1;
            byte_idx_reg <= 2'h0;
            if (hwdata_in[18:16] == KIND_VECTOR)
            begin
               // Four-byte entry at type times four.
               off_reg       <= {6'h00, hwdata_in[15:8], 2'h0};
               byte_last_reg <= 2'h3;
            end
            else
            begin
               off_reg       <= hwdata_in[15:0];
               byte_last_reg <= {1'b0, hwdata_in[REQ_WORD_BIT]};
            end
         end
         else if (state_reg == ST_T4)
         begin
            rdata_reg[byte_idx_reg*8 +: 8] <= low_addr_data_lines_in;
            idle_cnt_reg <= idle_cfg_reg;
            if (byte_idx_reg == byte_last_reg)
            begin
               pend_reg <= 1'b0;
               boot_reg <= 1'b0;
               if (kind == KIND_VECTOR && !boot_reg)
                  ip_reg <= rdata_reg[15:0];
            end
            else
            begin
               // Next byte lives at the next higher address.
               byte_idx_reg <= byte_idx_reg + 2'h1;
               off_reg      <= off_reg + 16'h0001;
            end
         end
         else if (state_reg == ST_IDLE && idle_cnt_reg != 4'h0)
            idle_cnt_reg <= idle_cnt_reg - 4'h1;
      end
   end

   // Pin drive. Low lines: address in T1, write data T2..T4; upper lines:
   // address in T1, status afterwards.
   always_comb
   begin
      pins_next = '0;
      pins_next.cyc   = CYC_PASSIVE;
      pins_next.den_n = 1'b1;
      pins_next.dtr   = 1'b0;
      if (state_next != ST_IDLE)
      begin
         pins_next.mid = cur.addr[15:8];
         pins_next.cyc = cur.cyc;
         pins_next.dtr = cur.is_write;
      end
      if (state_next == ST_T1)
      begin
         pins_next.ad_out = cur.addr[7:0];
         pins_next.ad_oe  = 1'b1;
         pins_next.upper  = cur.addr[19:16];
         pins_next.ale    = 1'b1;
      end
      else if (state_next != ST_IDLE)
      begin
         // Status bits 6..3.
         pins_next.upper = {1'b0, ie_reg, cur.seg};
         pins_next.ad_out = wdata_reg[byte_idx_reg*8 +: 8];
         pins_next.ad_oe  = cur.is_write;
         // Transceiver enabled only in data states; reads skip turnaround T2.
         pins_next.den_n  = !(cur.is_write || state_next != ST_T2);
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         low_addr_data_lines_out     <= 8'h00;
         low_addr_data_lines_oe_out  <= 1'b0;
         middle_address_lines_out    <= 8'h00;
         upper_addr_status_lines_out <= 4'h0;
         addr_latch_out              <= 1'b0;
         cycle_status_bit0_out       <= 1'b1;
         cycle_status_bit1_out       <= 1'b1;
         cycle_status_bit2_out       <= 1'b1;
         data_enable_n_out           <= 1'b1;
         transmit_receive_dir_out    <= 1'b0;
         lock_n_out                  <= 1'b1;
         queue_status_out            <= 2'h0;
         min_mode_out                <= 1'b0;
         busy_out                    <= 1'b0;
      end
      else
      begin
         low_addr_data_lines_out     <= pins_next.ad_out;
         low_addr_data_lines_oe_out  <= pins_next.ad_oe;
         middle_address_lines_out    <= pins_next.mid;
         upper_addr_status_lines_out <= pins_next.upper;
         // Strap picks the personality; min-mode strobes idle in max mode.
         addr_latch_out              <= pins_next.ale && mode_sync_reg;
         cycle_status_bit0_out       <= pins_next.cyc[0];
         cycle_status_bit1_out       <= pins_next.cyc[1];
         cycle_status_bit2_out       <= pins_next.cyc[2];
         data_enable_n_out           <= mode_sync_reg ? pins_next.den_n : 1'b1;
         transmit_receive_dir_out    <= mode_sync_reg && pins_next.dtr;
         // No locked sequences or queue reporting here; held inactive.
         lock_n_out                  <= 1'b1;
         queue_status_out            <= 2'h0;
         min_mode_out                <= mode_sync_reg;
         busy_out                    <= pend_reg;
      end
   end

   // Read side of the register bus.
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         hrdata_out <= 32'h0000_0000;
      else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
      begin
         if (haddr_in[7:0] == CTRL_OFS)
            hrdata_out <= {24'h0, idle_cfg_reg, 3'h0, ie_reg};
         else if (haddr_in[7:0] == SEG_CS_OFS)
            hrdata_out <= {16'h0, cs_reg};
         else if (haddr_in[7:0] == SEG_SS_OFS)
            hrdata_out <= {16'h0, ss_reg};
         else if (haddr_in[7:0] == SEG_DS_OFS)
            hrdata_out <= {16'h0, ds_reg};
         else if (haddr_in[7:0] == SEG_ES_OFS)
            hrdata_out <= {16'h0, es_reg};
         else if (haddr_in[7:0] == REQ_OFS)
            hrdata_out <= req_reg;
         else if (haddr_in[7:0] == WDATA_OFS)
            hrdata_out <= wdata_reg;
         else if (haddr_in[7:0] == STATUS_OFS)
            hrdata_out <= {24'h0, state_reg, mode_sync_reg, pend_reg};
         else if (haddr_in[7:0] == RDATA_OFS)
            hrdata_out <= rdata_reg;
         else if (haddr_in[7:0] == VECTOR_OFS)
            hrdata_out <= {cs_reg, ip_reg};
         else
            hrdata_out <= 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end
      else
      begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end
   end

   ale_first_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      addr_latch_out |-> $past(state_next == ST_T1)) else $error("strobe outside T1");
   cycle_len_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      state_reg == ST_T1 |=> state_reg == ST_T2 ##1 state_reg == ST_T3)
      else $error("short bus cycle");
   wait_hold_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state_reg == ST_T3 && !rdy_sync_reg) |=> state_reg == ST_TW)
      else $error("no wait state");
   io_upper_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state_next == ST_T1 && cur.is_io) |=> upper_addr_status_lines_out == 4'h0)
      else $error("io upper nonzero");
   status_six_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state_reg == ST_T3) |-> upper_addr_status_lines_out[3] == 1'b0)
      else $error("sixth status set");
   ie_mirror_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state_reg == ST_T2 && $stable(ie_reg)) |-> upper_addr_status_lines_out[2] == ie_reg)
      else $error("ie status mismatch");
   max_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      !min_mode_out |=> !addr_latch_out || $past(mode_sync_reg))
      else $error("strobe in max mode");
   boot_fetch_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (boot_reg && state_reg == ST_T1) |-> upper_addr_status_lines_out == 4'hf)
      else $error("boot not at top");
   mid_stable_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state_reg == ST_T1) |=> $stable(middle_address_lines_out))
      else $error("middle lines moved");
endmodule // bus_cycle_unit

// file: inc/bus_cycle_pkg.sv
// Purpose: Shared constants and carrier types for the processor bus cycle block.
// Assumes: 10 MHz reference clock, one bus state per clock.
// Notes:   Register offsets are byte addresses on the AHB-Lite register bus.
package bus_cycle_pkg;

   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] SEG_CS_OFS   = 8'h04;
   localparam logic [7:0] SEG_SS_OFS   = 8'h08;
   localparam logic [7:0] SEG_DS_OFS   = 8'h0c;
   localparam logic [7:0] SEG_ES_OFS   = 8'h10;
   localparam logic [7:0] REQ_OFS      = 8'h14;
   localparam logic [7:0] WDATA_OFS    = 8'h18;
   localparam logic [7:0] STATUS_OFS   = 8'h1c;
   localparam logic [7:0] RDATA_OFS    = 8'h20;
   localparam logic [7:0] VECTOR_OFS   = 8'h24;

   // Control register fields.
   localparam int CTRL_IE_BIT   = 0;
   localparam int CTRL_IDLE_LSB = 4;
   localparam int CTRL_IDLE_W   = 4;

   // Request register fields: offset[15:0], kind[18:16], seg[21:20], word[24],
   // direct port form [25], interrupt vector type [15:8] for vector requests.
   localparam int REQ_OFF_LSB  = 0;
   localparam int REQ_KIND_LSB = 16;
   localparam int REQ_SEG_LSB  = 20;
   localparam int REQ_OVR_BIT  = 22;
   localparam int REQ_WORD_BIT = 24;
   localparam int REQ_DIR_BIT  = 25;

   // Request kinds.
   localparam logic [2:0] KIND_FETCH  = 3'h0;
   localparam logic [2:0] KIND_MEMRD  = 3'h1;
   localparam logic [2:0] KIND_MEMWR  = 3'h2;
   localparam logic [2:0] KIND_IORD   = 3'h3;
   localparam logic [2:0] KIND_IOWR   = 3'h4;
   localparam logic [2:0] KIND_STACK  = 3'h5;
   localparam logic [2:0] KIND_STRDST = 3'h6;
   localparam logic [2:0] KIND_VECTOR = 3'h7;

   // Cycle-type status codes (bit2 bit1 bit0).
   localparam logic [2:0] CYC_INTA    = 3'h0;
   localparam logic [2:0] CYC_IORD    = 3'h1;
   localparam logic [2:0] CYC_IOWR    = 3'h2;
   localparam logic [2:0] CYC_HALT    = 3'h3;
   localparam logic [2:0] CYC_FETCH   = 3'h4;
   localparam logic [2:0] CYC_MEMRD   = 3'h5;
   localparam logic [2:0] CYC_MEMWR   = 3'h6;
   localparam logic [2:0] CYC_PASSIVE = 3'h7;

   // Segment status codes.
   localparam logic [1:0] SEG_EXTRA = 2'h0;
   localparam logic [1:0] SEG_STACK = 2'h1;
   localparam logic [1:0] SEG_CODE  = 2'h2;
   localparam logic [1:0] SEG_DATA  = 2'h3;

   // Reset values and reserved regions.
   localparam logic [15:0] RESET_CS     = 16'hffff;
   localparam logic [15:0] RESET_IP     = 16'h0000;
   localparam logic [15:0] RESET_SEG    = 16'h0000;
   localparam logic [19:0] VECTOR_BASE  = 20'h00000;
   localparam logic [15:0] DIRECT_IO_MASK = 16'h00ff;
   localparam logic [3:0]  IDLE_RESET   = 4'h0;

   typedef struct packed {
      logic [19:0] addr;
      logic [2:0]  cyc;
      logic [1:0]  seg;
      logic        is_io;
      logic        is_write;
   } cycle_req_type;

   typedef struct packed {
      logic [7:0] ad_out;
      logic       ad_oe;
      logic [7:0] mid;
      logic [3:0] upper;
      logic       ale;
      logic [2:0] cyc;
      logic       den_n;
      logic       dtr;
   } pins_type;

endpackage

// file: hw/phys_addr_gen.sv
// Purpose: Forms a 20-bit physical address from segment base and offset.
// Assumes: Combinational, same clock domain as the caller.
// Notes:   I/O cycles bypass segmentation entirely.
`timescale 1ns/1ps
module phys_addr_gen
   import bus_cycle_pkg::*;
(
   input  wire logic [15:0] seg_base_in,
   input  wire logic [15:0] offset_in,
   input  wire logic        is_io_in,
   input  wire logic        direct_io_in,
   output logic      [19:0] phys_out
);
   logic [19:0] sum;

   always_comb
   begin
      // The sum is kept at 20 bits so the carry out of the top wraps.
      sum = {seg_base_in, 4'h0} + {4'h0, offset_in};
      if (is_io_in)
      begin
         // Ports sit on the low sixteen lines, the top four are zero.
         if (direct_io_in)
            phys_out = {4'h0, offset_in & DIRECT_IO_MASK};
         else
            phys_out = {4'h0, offset_in};
      end
      else
         phys_out = sum;
   end
endmodule // phys_addr_gen

// file: hw/seg_select.sv
// Purpose: Chooses the segment for a memory request.
// Assumes: Override code is meaningful only when the override flag is set.
// Notes:   Instruction fetch never takes an override.
`timescale 1ns/1ps
module seg_select
   import bus_cycle_pkg::*;
(
   input  wire logic [2:0] kind_in,
   input  wire logic       bp_rel_in,
   input  wire logic       ovr_in,
   input  wire logic [1:0] ovr_seg_in,
   output logic      [1:0] seg_out
);
   always_comb
   begin
      // Automatic choice by kind of reference.
      if (kind_in == KIND_FETCH || kind_in == KIND_VECTOR)
         seg_out = SEG_CODE;
      else if (kind_in == KIND_STACK)
         seg_out = SEG_STACK;
      else if (ovr_in)
         seg_out = ovr_seg_in;
      else if (kind_in == KIND_STRDST)
         seg_out = SEG_EXTRA;
      else if (bp_rel_in)
         seg_out = SEG_STACK;
      else
         seg_out = SEG_DATA;
   end
endmodule // seg_select

// file: sim/bus_partner.sv
// Purpose: Memory and port model on the far side of the multiplexed bus.
// Assumes: Minimum mode strobes, one bus state per clock.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/1ps
module bus_partner
   import bus_cycle_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        stall_in,
   input  wire logic        ale_in,
   input  wire logic        den_n_in,
   input  wire logic        oe_in,
   input  wire logic [7:0]  ad_in,
   input  wire logic [7:0]  mid_in,
   input  wire logic [3:0]  up_in,
   input  wire logic [2:0]  cyc_in,
   output logic             ready_out,
   output logic      [7:0]  ad_out,
   output logic      [19:0] addr_out,
   output logic      [6:0]  stat_out
);
   logic [7:0] mem [256];
   logic [7:0] last;
   logic [2:0] hold;
   logic       ale_seen;
   initial
   begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
      {ready_out, last, hold, ale_seen} = {1'b1, 8'h0, 3'h0, 1'b0};
   end
   assign ad_out = (!den_n_in && !oe_in) ? mem[addr_out[7:0]] : ~last;
   always @(posedge clk_in)
   begin
      last <= ad_out;
      ale_seen <= ale_in;
      if (ale_in) addr_out <= {up_in, mid_in, ad_in};
      if (ale_seen) stat_out <= {up_in, cyc_in};
      if (!den_n_in && oe_in) mem[addr_out[7:0]] <= ad_in;
      hold <= (ale_in && stall_in) ? 3'h5 : hold - 3'(hold != 3'h0);
      // The processor sees ready through two flops, so not-ready is held from the
      // request onward and released as a single clock of ready when the count reaches two.
      ready_out <= !stall_in || hold == 3'h2;
   end
endmodule // bus_partner

// file: sim/cpu_bus_cycle_interface_test.sv
// Purpose: Self-checking bench for the bus cycle unit.
// Assumes: Register bus answers with no wait; strap high unless changed.
// Notes:   Rows hold a request, its address and its status word.
`timescale 1ns/1ps
module cpu_bus_cycle_interface_test
   import bus_cycle_pkg::*;
;
   logic        clk = 0, rst_n = 0, hw = 0, strap = 1, stall = 0;
   logic [1:0]  ht = 0;
   logic [31:0] ha = 0, wd = 0, rd, hr;
   logic        hro, ale, data_enable_n, oe, rdy;
   logic [7:0]  ado, adp, mid;
   logic [3:0]  up;
   logic [2:0]  cyc;
   logic [19:0] pa;
   logic [6:0]  ps;
   int          bad_count = 0, cmp_count = 0, n, n0;
   logic [31:0] rq [9] = '{32'h10, 32'h10020, 32'h810040, 32'h410044, 32'h31234,
                           32'h2031234, 32'h8000, 32'h4ab70, 32'h20050};
   logic [19:0] ea [9] = '{20'h10010, 20'h20020, 20'h30040, 20'h00034, 20'h01234,
                           20'h00034, 20'h18000, 20'h0ab70, 20'h20050};
   logic [6:0]  es [9] = '{{2'h1, SEG_CODE, CYC_FETCH}, {2'h1, SEG_DATA, CYC_MEMRD},
      {2'h1, SEG_STACK, CYC_MEMRD}, {2'h1, SEG_EXTRA, CYC_MEMRD}, {2'h1, SEG_CODE, CYC_IORD},
      {2'h1, SEG_CODE, CYC_IORD}, {2'h1, SEG_CODE, CYC_FETCH}, {2'h1, SEG_CODE, CYC_IOWR},
      {2'h1, SEG_DATA, CYC_MEMWR}};
   always #50 clk = ~clk;
   bus_cycle_unit dut (.ref_clk_in(clk), .resetn_in(rst_n), .haddr_in(ha), .htrans_in(ht),
      .hwrite_in(hw), .hsize_in(3'h2), .hwdata_in(wd), .hsel_in(1'b1), .hready_in(hro),
      .hrdata_out(hr), .hreadyout_out(hro), .hresp_out(), .mode_strap_in(strap),
      .ready_in(rdy), .low_addr_data_lines_in(oe ? ado : adp), .low_addr_data_lines_out(ado),
      .low_addr_data_lines_oe_out(oe), .middle_address_lines_out(mid),
      .upper_addr_status_lines_out(up), .addr_latch_out(ale), .cycle_status_bit0_out(cyc[0]),
      .cycle_status_bit1_out(cyc[1]), .cycle_status_bit2_out(cyc[2]), .data_enable_n_out(data_enable_n),
      .transmit_receive_dir_out(), .lock_n_out(), .queue_status_out(), .min_mode_out(),
      .busy_out());
   bus_partner p (.clk_in(clk), .stall_in(stall), .ale_in(ale), .den_n_in(data_enable_n), .oe_in(oe),
      .ad_in(oe ? ado : adp), .mid_in(mid), .up_in(up), .cyc_in(cyc), .ready_out(rdy),
      .ad_out(adp), .addr_out(pa), .stat_out(ps));
   task chk(string s, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) $display("MISMATCH %s exp %h seen %h", s, exp, seen);
      if (seen !== exp) bad_count++;
   endtask
   task bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk) {ht, ha, hw} <= {2'h2, 24'h0, a, w};
      do @(posedge clk); while (hro !== 1'b1);
      {ht, wd} <= {2'h0, d};
      do @(posedge clk); while (hro !== 1'b1);
      rd = hr;
   endtask
   task req(logic [31:0] r);
      bus(1, REQ_OFS, r);
      n = 0;
      do begin bus(0, STATUS_OFS, 0); n++; end while (rd[0] !== 1'b0 && n < 60);
      chk("request done", rd[0], 0);
      bus(0, RDATA_OFS, 0);
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      chk("reset status", {cyc, data_enable_n}, 4'hf);
      rst_n <= 1;
      bus(1, CTRL_OFS, 1);
      bus(1, SEG_CS_OFS, 32'h1000);
      bus(1, SEG_SS_OFS, 32'h3000);
      bus(1, SEG_DS_OFS, 32'h2000);
      bus(1, SEG_ES_OFS, 32'hffff);
      for (int i = 0; i < 9; i++)
      begin
         req(rq[i]);
         if (i == 1) n0 = n;
         chk("address", 32'(pa), 32'(ea[i]));
         chk("status", 32'(ps), 32'(es[i]));
         if (i < 6) chk("read byte", rd[7:0], ea[i][7:0] ^ 8'h5a);
      end
      $display("row tests done");
      req(32'h70200);
      bus(0, VECTOR_OFS, 0);
      chk("vector", rd, 32'h51505352);
      bus(1, WDATA_OFS, 32'hbeef);
      req(32'h1020060);
      chk("word addr", 32'(pa), 32'h20061);
      chk("word mem", {p.mem[8'h61], p.mem[8'h60]}, 32'hbeef);
      req(32'h1010060);
      chk("word read", rd[15:0], 32'hbeef);
      stall <= 1;
      req(32'h10020);
      chk("wait data", rd[7:0], 32'h7a);
      chk("wait longer", 32'(n > n0), 1);
      stall <= 0;
      $display("word and wait tests done");
      strap <= 0;
      repeat (4) @(posedge clk);
      bus(0, STATUS_OFS, 0);
      chk("mode", rd[1], 0);
      $display("mode test done");
      stop_test;
   end
   initial
   begin
      #500_000;
      bad_count++;
      stop_test;
   end
endmodule // cpu_bus_cycle_interface_test
